// File: logic/tpc_regs.sv
/*
 * tpc_regs: configuration register bank for the transmit path and the
 * parallel data interface, with serial programming port, interface mode
 * decode, transmit capture, receive formatting and digital loop-back.
 * assumes: all pins synchronous to clk_sys; the serial clock is much
 * slower than clk_sys; tx_processed is the transmit digital path output.
 */
// Functional notes
// RULE_01: quick-settle bit selects fast gain settling
// RULE_02: tx data straight binary unless format bit
// RULE_03: rx data straight binary unless format bit
// RULE_04: capture tx on clock rise, inverse falls
// RULE_05: interpolation field: bypass, 2x, 4x
// RULE_06: loop-back sends tx path to rx bus
// RULE_07: software sets full duplex for loop-back
// RULE_08: duplex bit high is full duplex, reset high
// RULE_09: duplex and width pick mode; clone overrides
// RULE_10: half-duplex direction high transmit, low receive
// RULE_11: width bit high 12-bit, low 24-bit
// RULE_12: override bit replaces pin for direction
// RULE_13: software sets clone bit and clock field
// RULE_14: gain applies right after its write; code holds it until power-down ends when the sync bit is set
// RULE_15: interpolation code 11 leaves filters bypassed
`timescale 1ns/1ps
`default_nettype none

module tpc_regs #(
    parameter int unsigned SAMPLE_W    = 12,
    parameter int unsigned SAMPLE_CLOCK_OUTPUT_HALF = tpc_pkg::SAMPLE_CLOCK_OUTPUT_HALF_DEFAULT
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic                  spi_sclk,
    input  wire logic                  spi_cs_n,
    input  wire logic                  spi_sdi,
    output logic                       spi_sdo,
    output logic                       spi_sdo_oe_n,
    input  wire logic                  tx_rx_select_pin,
    input  wire logic                  tx_power_down,
    input  wire logic [SAMPLE_W-1:0]   tx_bus_in,
    input  wire logic [SAMPLE_W-1:0]   tx_processed,
    input  wire logic [SAMPLE_W-1:0]   adc_sample,
    output logic                       sample_clock_output,
    output logic [SAMPLE_W-1:0]        tx_sample,
    output logic                       tx_sample_valid,
    output logic [SAMPLE_W-1:0]        rx_bus_out,
    output logic [7:0]                 tx_gain_amp_level,
    output logic                       tx_gain_amp_apply,
    output tpc_pkg::tpc_cfg_t          cfg
);
    import tpc_pkg::*;

    initial begin
        if (SAMPLE_W < 2 || SAMPLE_W > 24) $error("tpc_regs: SAMPLE_W out of range");
        if (SAMPLE_CLOCK_OUTPUT_HALF < 1 || SAMPLE_CLOCK_OUTPUT_HALF > 255) $error("tpc_regs: SAMPLE_CLOCK_OUTPUT_HALF out of range");
    end

    typedef enum logic [2:0] {
        SER_IDLE  = 3'h1,
        SER_INSTR = 3'h2,
        SER_DATA  = 3'h4
    } tpc_ser_state_t;

    function automatic logic [7:0] read_mux(input logic [6:0] a, input logic [7:0] g,
                                            input logic [7:0] u, input logic [7:0] f,
                                            input logic [7:0] m);
        logic [7:0] r;
        r = 8'h00;
        if (a == OFF_TX_GAIN_LEVEL) begin
            r = g;
        end else if (a == OFF_TX_GAIN_UPDATE_CONTROL) begin
            r = u;
        end else if (a == OFF_DATA_FORMAT_AND_INTERP) begin
            r = f;
        end else if (a == OFF_INTERFACE_MODE_CONFIG) begin
            r = m;
        end
        return r;
    endfunction : read_mux

    // serial port state
    tpc_ser_state_t ser_q, ser_d;
    logic [4:0]     cnt_q, cnt_d;
    logic [7:0]     sh_q, sh_d;
    logic [6:0]     addr_q, addr_d;
    logic           rd_q, rd_d;
    logic [7:0]     out_q, out_d;
    logic           sdo_q, sdo_d;
    logic           oe_n_q, oe_n_d;
    logic           sclk_q;
    logic           wr_stb;
    logic           sclk_rise, sclk_fall;

    // register state
    logic [7:0] gain_q, gain_d;
    logic [7:0] upd_q, upd_d;
    logic [7:0] fmt_q, fmt_d;
    logic [7:0] mode_q, mode_d;
    logic       pend_q, pend_d;
    logic       apply_q, apply_d;
    logic       pwrdn_q;

    assign sclk_rise = spi_sclk & ~sclk_q;
    assign sclk_fall = ~spi_sclk & sclk_q;

    always_comb begin
        ser_d  = ser_q;
        cnt_d  = cnt_q;
        sh_d   = sh_q;
        addr_d = addr_q;
        rd_d   = rd_q;
        out_d  = out_q;
        sdo_d  = sdo_q;
        oe_n_d = oe_n_q;
        wr_stb = 1'b0;
        case (ser_q)
            SER_IDLE: begin
                oe_n_d = 1'b1;
                cnt_d  = 5'h00;
                if (!spi_cs_n) begin
                    ser_d = SER_INSTR;
                end
            end
            SER_INSTR: begin
                if (spi_cs_n) begin
                    ser_d = SER_IDLE;
                end else if (sclk_rise) begin
                    sh_d  = {sh_q[6:0], spi_sdi};
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q + 5'h01 == SER_INSTR_BITS) begin
                        rd_d   = sh_q[6];
                        addr_d = {sh_q[5:0], spi_sdi};
                        out_d  = read_mux({sh_q[5:0], spi_sdi}, gain_q, upd_q, fmt_q, mode_q);
                        ser_d  = SER_DATA;
                    end
                end
            end
            SER_DATA: begin
                if (spi_cs_n) begin
                    ser_d = SER_IDLE;
                end else if (cnt_q == SER_FRAME_BITS) begin
                    // frame done: last read bit stays driven, extra bits ignored
                    oe_n_d = oe_n_q;
                end else if (sclk_fall && rd_q) begin
                    // read data leaves msb first on falling edges
                    sdo_d  = out_q[7];
                    out_d  = {out_q[6:0], 1'b0};
                    oe_n_d = 1'b0;
                end else if (sclk_rise) begin
                    sh_d  = {sh_q[6:0], spi_sdi};
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q + 5'h01 == SER_FRAME_BITS) begin
                        wr_stb = ~rd_q;
                    end
                end
            end
            default: begin
                ser_d = SER_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ser_q  <= SER_IDLE;
            cnt_q  <= 5'h00;
            sh_q   <= 8'h00;
            addr_q <= 7'h00;
            rd_q   <= 1'b0;
            out_q  <= 8'h00;
            sdo_q  <= 1'b0;
            oe_n_q <= 1'b1;
            sclk_q <= 1'b0;
        end else begin
            ser_q  <= ser_d;
            cnt_q  <= cnt_d;
            sh_q   <= sh_d;
            addr_q <= addr_d;
            rd_q   <= rd_d;
            out_q  <= out_d;
            sdo_q  <= sdo_d;
            oe_n_q <= oe_n_d;
            sclk_q <= spi_sclk;
        end
    end

    assign spi_sdo      = sdo_q;
    assign spi_sdo_oe_n = oe_n_q;

    // register writes and gain application
    always_comb begin
        gain_d  = gain_q;
        upd_d   = upd_q;
        fmt_d   = fmt_q;
        mode_d  = mode_q;
        pend_d  = pend_q;
        apply_d = 1'b0;
        if (wr_stb) begin
            if (addr_q == OFF_TX_GAIN_LEVEL) begin
                gain_d = sh_d;
                pend_d = 1'b1;
            end else if (addr_q == OFF_TX_GAIN_UPDATE_CONTROL) begin
                upd_d = sh_d;
            end else if (addr_q == OFF_DATA_FORMAT_AND_INTERP) begin
                fmt_d = sh_d;
            end else if (addr_q == OFF_INTERFACE_MODE_CONFIG) begin
                mode_d = sh_d;
            end
        end
        // new gain level goes out the cycle after the write, its apply pulse one cycle later, unless held for power-down wake
        if (pend_q && (!upd_q[BIT_GAIN_SYNC_PWRDN] || (pwrdn_q && !tx_power_down))) begin
            apply_d = 1'b1; // see RULE_14
            pend_d  = wr_stb && addr_q == OFF_TX_GAIN_LEVEL;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gain_q  <= RST_TX_GAIN_LEVEL;
            upd_q   <= RST_TX_GAIN_UPDATE_CONTROL;
            fmt_q   <= RST_DATA_FORMAT_AND_INTERP;
            mode_q  <= RST_INTERFACE_MODE_CONFIG; // see RULE_08
            pend_q  <= 1'b0;
            apply_q <= 1'b0;
            pwrdn_q <= 1'b0;
        end else begin
            gain_q  <= gain_d;
            upd_q   <= upd_d;
            fmt_q   <= fmt_d;
            mode_q  <= mode_d;
            pend_q  <= pend_d;
            apply_q <= apply_d;
            pwrdn_q <= tx_power_down;
        end
    end

    assign tx_gain_amp_level = gain_q;
    assign tx_gain_amp_apply = apply_q;

    // configuration decode
    tpc_cfg_t cfg_d, cfg_q;

    always_comb begin
        cfg_d = cfg_q;
        cfg_d.gain_quick_settle  = upd_q[BIT_GAIN_QUICK]; // see RULE_01
        cfg_d.tx_twos_complement = fmt_q[BIT_TX_TWOS];
        cfg_d.rx_twos_complement = fmt_q[BIT_RX_TWOS];
        cfg_d.tx_inverse_sample  = fmt_q[BIT_TX_INV_SAMPLE];
        case (fmt_q[BIT_INTERP_MSB:BIT_INTERP_LSB])
            2'h1:    cfg_d.interp_rate = TPC_INTERP_X2; // see RULE_05
            2'h2:    cfg_d.interp_rate = TPC_INTERP_X4; // see RULE_05
            default: cfg_d.interp_rate = TPC_INTERP_BYPASS; // see RULE_15
        endcase
        cfg_d.loopback_active = mode_q[BIT_LOOPBACK];
        // loop-back always runs full-duplex timing; clone ignores duplex bit
        if (mode_q[BIT_LOOPBACK]) begin
            cfg_d.if_mode = TPC_FULL_DUPLEX_MODE; // see RULE_06
        end else if (mode_q[BIT_CLONE]) begin
            cfg_d.if_mode = TPC_CLONE_MODE; // see RULE_09
        end else if (mode_q[BIT_DUPLEX_SELECT]) begin
            cfg_d.if_mode = TPC_FULL_DUPLEX_MODE; // see RULE_08
        end else if (mode_q[BIT_HD_WIDTH_SELECT]) begin
            cfg_d.if_mode = TPC_HALF_DUPLEX_12BIT_MODE; // see RULE_11
        end else begin
            cfg_d.if_mode = TPC_HALF_DUPLEX_24BIT_MODE; // see RULE_11
        end
        // high is transmit; override swaps the pin for the register bit
        cfg_d.half_duplex_direction = mode_q[BIT_DIR_OVERRIDE] ? mode_q[BIT_HD_DIRECTION]
                                                               : tx_rx_select_pin; // see RULE_12
        if (cfg_d.if_mode == TPC_FULL_DUPLEX_MODE) begin
            cfg_d.half_duplex_direction = 1'b0;
        end // see RULE_10
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= '{gain_quick_settle: 1'b0, tx_twos_complement: 1'b0,
                       rx_twos_complement: 1'b0, tx_inverse_sample: 1'b0,
                       interp_rate: TPC_INTERP_BYPASS, if_mode: TPC_FULL_DUPLEX_MODE,
                       half_duplex_direction: 1'b0, loopback_active: 1'b0};
        end else begin
            cfg_q <= cfg_d;
        end
    end

    assign cfg = cfg_q;

    // sample clock divider and transmit capture
    logic [7:0]          div_q, div_d;
    logic                ck_q, ck_d;
    logic                cap_en;
    logic [SAMPLE_W-1:0] txs_q, txs_d;
    logic                txv_q, txv_d;
    logic [SAMPLE_W-1:0] rx_q, rx_d;
    logic [SAMPLE_W-1:0] msb_mask;

    assign msb_mask = {1'b1, {(SAMPLE_W-1){1'b0}}};

    always_comb begin
        div_d = div_q + 8'h01;
        ck_d  = ck_q;
        if (div_q == 8'(SAMPLE_CLOCK_OUTPUT_HALF - 1)) begin
            div_d = 8'h00;
            ck_d  = ~ck_q;
        end
        // the edge is the divider flip, so capture lines up with the pin edge
        cap_en = (div_q == 8'(SAMPLE_CLOCK_OUTPUT_HALF - 1))
                 && (ck_q == cfg_q.tx_inverse_sample); // see RULE_04
        txs_d = txs_q;
        txv_d = 1'b0;
        if (cap_en && (cfg_q.if_mode != TPC_HALF_DUPLEX_12BIT_MODE || cfg_q.loopback_active
                       || cfg_q.half_duplex_direction || cfg_q.if_mode == TPC_FULL_DUPLEX_MODE
                       || cfg_q.if_mode == TPC_HALF_DUPLEX_24BIT_MODE
                       || cfg_q.if_mode == TPC_CLONE_MODE)) begin
            // internal form is twos complement; straight binary needs its msb flipped
            txs_d = cfg_q.tx_twos_complement ? tx_bus_in : (tx_bus_in ^ msb_mask); // see RULE_02
            txv_d = 1'b1;
        end
        // adc words arrive straight binary
        if (cfg_q.loopback_active) begin
            rx_d = tx_processed; // see RULE_06
        end else begin
            rx_d = cfg_q.rx_twos_complement ? (adc_sample ^ msb_mask) : adc_sample; // see RULE_03
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 8'h00;
            ck_q  <= 1'b0;
            txs_q <= '0;
            txv_q <= 1'b0;
            rx_q  <= '0;
        end else begin
            div_q <= div_d;
            ck_q  <= ck_d;
            txs_q <= txs_d;
            txv_q <= txv_d;
            rx_q  <= rx_d;
        end
    end

    assign sample_clock_output = ck_q;
    assign tx_sample           = txs_q;
    assign tx_sample_valid     = txv_q;
    assign rx_bus_out          = rx_q;

endmodule : tpc_regs

`default_nettype wire

// File: logic/tpc_pkg.sv
/*
 * tpc_pkg: register map, field positions, reset values and shared types
 * for the transmit-path and interface configuration register bank.
 * assumes: one 125 MHz system clock, registers written over the serial port.
 */
package tpc_pkg;

    localparam int unsigned ADDR_W = 7;
    localparam int unsigned DATA_W = 8;

    // register offsets
    localparam logic [6:0] OFF_TX_GAIN_LEVEL          = 7'h0b;
    localparam logic [6:0] OFF_TX_GAIN_UPDATE_CONTROL = 7'h0c;
    localparam logic [6:0] OFF_DATA_FORMAT_AND_INTERP = 7'h0d;
    localparam logic [6:0] OFF_INTERFACE_MODE_CONFIG  = 7'h0e;

    // reset values
    localparam logic [7:0] RST_TX_GAIN_LEVEL          = 8'hff;
    localparam logic [7:0] RST_TX_GAIN_UPDATE_CONTROL = 8'h00;
    localparam logic [7:0] RST_DATA_FORMAT_AND_INTERP = 8'h00;
    localparam logic [7:0] RST_INTERFACE_MODE_CONFIG  = 8'h10;

    // tx_gain_update_control fields
    localparam int unsigned BIT_GAIN_SYNC_PWRDN  = 6;
    localparam int unsigned BIT_GAIN_QUICK       = 4;
    // data_format_and_interpolation fields
    localparam int unsigned BIT_TX_TWOS          = 7;
    localparam int unsigned BIT_RX_TWOS          = 6;
    localparam int unsigned BIT_TX_INV_SAMPLE    = 5;
    localparam int unsigned BIT_INTERP_MSB       = 1;
    localparam int unsigned BIT_INTERP_LSB       = 0;
    // interface_mode_config fields
    localparam int unsigned BIT_LOOPBACK         = 5;
    localparam int unsigned BIT_DUPLEX_SELECT    = 4;
    localparam int unsigned BIT_HD_DIRECTION     = 3;
    localparam int unsigned BIT_HD_WIDTH_SELECT  = 2;
    localparam int unsigned BIT_DIR_OVERRIDE     = 1;
    localparam int unsigned BIT_CLONE            = 0;

    // serial frame: instruction byte then data byte
    localparam logic [4:0] SER_FRAME_BITS = 5'h10;
    localparam logic [4:0] SER_INSTR_BITS = 5'h08;
    localparam int unsigned BIT_SER_READ  = 7;

    // sample clock output divider, in system clocks per half period
    localparam int unsigned SAMPLE_CLOCK_OUTPUT_HALF_DEFAULT = 2;

    typedef enum logic [1:0] {
        TPC_INTERP_BYPASS = 2'h0,
        TPC_INTERP_X2     = 2'h1,
        TPC_INTERP_X4     = 2'h2,
        TPC_INTERP_RSVD   = 2'h3
    } tpc_interp_t;

    typedef enum logic [3:0] {
        TPC_FULL_DUPLEX_MODE       = 4'h1,
        TPC_HALF_DUPLEX_12BIT_MODE = 4'h2,
        TPC_HALF_DUPLEX_24BIT_MODE = 4'h4,
        TPC_CLONE_MODE             = 4'h8
    } tpc_if_mode_t;

    typedef struct packed {
        logic         gain_quick_settle;
        logic         tx_twos_complement;
        logic         rx_twos_complement;
        logic         tx_inverse_sample;
        tpc_interp_t  interp_rate;
        tpc_if_mode_t if_mode;
        logic         half_duplex_direction;
        logic         loopback_active;
    } tpc_cfg_t;

endpackage : tpc_pkg

// File: test/tpc_regs_props.sv
/* tpc_regs_props: port assertions for the configuration register bank.
 * assumes: bound onto tpc_regs, one clock, active-low async reset. */
`timescale 1ns/1ps
`default_nettype none
module tpc_regs_props
    import tpc_pkg::*;
#(
    parameter int unsigned SAMPLE_W = 12
) (
    input wire logic                clk_sys,
    input wire logic                rst_n,
    input wire logic [SAMPLE_W-1:0] tx_bus_in,
    input wire logic [SAMPLE_W-1:0] tx_processed,
    input wire logic [SAMPLE_W-1:0] adc_sample,
    input wire logic                sample_clock_output,
    input wire logic [SAMPLE_W-1:0] tx_sample,
    input wire logic                tx_sample_valid,
    input wire logic [SAMPLE_W-1:0] rx_bus_out,
    input wire logic                tx_gain_amp_apply,
    input wire tpc_pkg::tpc_cfg_t   cfg
);
    localparam logic [SAMPLE_W-1:0] MSB = {1'b1, {(SAMPLE_W-1){1'b0}}};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    chk_reset_full: assert property ($rose(rst_n) |-> cfg.if_mode == TPC_FULL_DUPLEX_MODE)
        else $error("mode after reset not full duplex");
    chk_loop_rx: assert property (($past(cfg.loopback_active) && $past(rst_n))
        |-> rx_bus_out == $past(tx_processed)) else $error("loop-back data wrong");
    chk_rx_format: assert property ((!$past(cfg.loopback_active) && $past(rst_n))
        |-> rx_bus_out == ($past(adc_sample) ^ ($past(cfg.rx_twos_complement) ? MSB : '0)))
        else $error("receive format wrong");
    chk_tx_format: assert property ((tx_sample_valid && $stable(cfg))
        |-> tx_sample == (tx_bus_in ^ (cfg.tx_twos_complement ? '0 : MSB)))
        else $error("transmit format wrong");
    chk_tx_edge: assert property ((tx_sample_valid && $stable(cfg))
        |-> sample_clock_output != cfg.tx_inverse_sample) else $error("capture edge wrong");
    chk_loop_mode: assert property (cfg.loopback_active |-> cfg.if_mode == TPC_FULL_DUPLEX_MODE)
        else $error("loop-back outside full duplex");
    chk_fd_dir: assert property (cfg.if_mode == TPC_FULL_DUPLEX_MODE |-> !cfg.half_duplex_direction)
        else $error("direction set in full duplex");
    chk_interp_code: assert property (cfg.interp_rate != TPC_INTERP_RSVD)
        else $error("reserved interpolation code");
    chk_apply_once: assert property (tx_gain_amp_apply |=> !tx_gain_amp_apply [*8])
        else $error("gain apply not single");

    cov_loop: cover property (cfg.loopback_active ##1 cfg.loopback_active);
    cov_inv: cover property (tx_sample_valid && cfg.tx_inverse_sample);
    cov_apply: cover property (tx_gain_amp_apply);
    cov_half_duplex_12bit_mode: cover property (cfg.if_mode == TPC_HALF_DUPLEX_12BIT_MODE);
endmodule : tpc_regs_props

bind tpc_regs tpc_regs_props #(.SAMPLE_W(SAMPLE_W)) i_props (
    .clk_sys, .rst_n, .tx_bus_in, .tx_processed, .adc_sample, .sample_clock_output,
    .tx_sample, .tx_sample_valid, .rx_bus_out, .tx_gain_amp_apply, .cfg
);
`default_nettype wire

// File: test/tpc_bb_model.sv
/* tpc_bb_model: baseband side of the parallel bus and a stand-in transmit path.
 * assumes: sees the sample clock and the capture-edge setting of the bank. */
`timescale 1ns/1ps
`default_nettype none
module tpc_bb_model #(
    parameter int unsigned SAMPLE_W = 12
) (
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    input  wire logic                sample_clock_output,
    input  wire logic                inverse,
    output logic [SAMPLE_W-1:0]      tx_bus_in,
    output logic [SAMPLE_W-1:0]      tx_processed
);
    logic       clk_q;
    logic [1:0] hold_q;
    // new word a little after the idle edge, so it is steady across the capture edge
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clk_q     <= 1'b0;
            hold_q    <= 2'h0;
            tx_bus_in <= '0;
        end else begin
            clk_q <= sample_clock_output;
            if (clk_q != sample_clock_output && sample_clock_output == inverse) hold_q <= 2'h2;
            else if (hold_q != 2'h0) hold_q <= hold_q - 2'h1;
            if (hold_q == 2'h1) tx_bus_in <= SAMPLE_W'($urandom);
        end
        tx_processed <= SAMPLE_W'($urandom);
    end
endmodule : tpc_bb_model
`default_nettype wire

// File: test/tb.sv
/* tb: self-checking bench for tpc_regs over its serial port.
 * assumes: tpc_bb_model on the parallel bus, checker bound in. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tpc_pkg::*;
    localparam int unsigned SW = 12;
    logic          clk_sys, rst_n, spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe_n;
    logic          tx_rx_select_pin, tx_power_down, sample_clock_output;
    logic          tx_sample_valid, tx_gain_amp_apply;
    logic [SW-1:0] tx_bus_in, tx_processed, adc_sample, tx_sample, rx_bus_out, p;
    logic [7:0]    tx_gain_amp_level, rd, m, d, g;
    tpc_cfg_t      cfg;
    int            n_mismatch = 0, check_count = 0, n_apply = 0, na;

    tpc_regs #(.SAMPLE_W(SW), .SAMPLE_CLOCK_OUTPUT_HALF(4)) i_dut (
        .clk_sys, .rst_n, .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo, .spi_sdo_oe_n,
        .tx_rx_select_pin, .tx_power_down, .tx_bus_in, .tx_processed, .adc_sample,
        .sample_clock_output, .tx_sample, .tx_sample_valid, .rx_bus_out,
        .tx_gain_amp_level, .tx_gain_amp_apply, .cfg
    );
    tpc_bb_model #(.SAMPLE_W(SW)) i_bb (
        .clk_sys, .rst_n, .sample_clock_output, .inverse(cfg.tx_inverse_sample),
        .tx_bus_in, .tx_processed
    );

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        adc_sample <= SW'($urandom);
        if (tx_gain_amp_apply === 1'b1) n_apply <= n_apply + 1;
    end

    task automatic clks(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : clks

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string w);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t %s got %h exp %h", $time, w, got, exp);
        end
    endtask : chk

    // one frame: read flag, address, data; slow phases keep sclk edges visible
    task automatic spi(input logic rw, input logic [6:0] a, input logic [7:0] v);
        logic [15:0] f;
        f = {rw, a, v};
        spi_cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spi_sdi <= f[i];
            clks(3);
            spi_sclk <= 1'b1;
            clks(3);
            if (i < 8) begin
                rd = {rd[6:0], spi_sdo};
                chk(16'(spi_sdo_oe_n), 16'(!rw), "sdo enable");
            end
            spi_sclk <= 1'b0;
        end
        clks(3);
        spi_cs_n <= 1'b1;
        clks(4);
        chk(16'(spi_sdo_oe_n), 16'h0001, "sdo release");
    endtask : spi

    function automatic tpc_if_mode_t exp_mode(input logic [7:0] v);
        if (v[5] || (!v[0] && v[4])) return TPC_FULL_DUPLEX_MODE;
        if (v[0]) return TPC_CLONE_MODE;
        return v[2] ? TPC_HALF_DUPLEX_12BIT_MODE : TPC_HALF_DUPLEX_24BIT_MODE;
    endfunction : exp_mode

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop

    initial begin
        #400000;
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        void'($urandom(32'hfffa));
        {rst_n, spi_sclk, spi_sdi, tx_rx_select_pin, tx_power_down} = 5'h00;
        spi_cs_n = 1'b1;
        clks(20);
        rst_n <= 1'b1;
        clks(1);
        chk(cfg.if_mode, TPC_FULL_DUPLEX_MODE, "reset mode");
        spi(1, OFF_TX_GAIN_LEVEL, 8'h00);
        chk(rd, RST_TX_GAIN_LEVEL, "rst gain");
        spi(1, OFF_TX_GAIN_UPDATE_CONTROL, 8'h00);
        chk(rd, RST_TX_GAIN_UPDATE_CONTROL, "rst update");
        spi(1, OFF_DATA_FORMAT_AND_INTERP, 8'h00);
        chk(rd, RST_DATA_FORMAT_AND_INTERP, "rst format");
        spi(1, OFF_INTERFACE_MODE_CONFIG, 8'h00);
        chk(rd, RST_INTERFACE_MODE_CONFIG, "rst mode reg");
        spi(0, 7'h20, 8'h5a);
        spi(1, 7'h20, 8'h00);
        chk(rd, 8'h00, "unmapped");
        for (int i = 0; i < 8; i++) begin
            d = {3'(i), 3'h0, 2'(i)};
            spi(0, OFF_DATA_FORMAT_AND_INTERP, d);
            clks(40);
            spi(1, OFF_DATA_FORMAT_AND_INTERP, 8'h00);
            chk(rd, d, "format readback");
            chk(cfg.tx_twos_complement, d[7], "tx format");
            chk(cfg.rx_twos_complement, d[6], "rx format");
            chk(cfg.tx_inverse_sample, d[5], "inverse");
            chk(cfg.interp_rate, (d[1:0] == 2'h3) ? 2'h0 : d[1:0], "interp");
        end
        for (int i = 0; i < 32; i++) begin
            m = 8'(i);
            tx_rx_select_pin <= 1'($urandom);
            spi(0, OFF_INTERFACE_MODE_CONFIG, m);
            chk(cfg.if_mode, exp_mode(m), "if mode");
            chk(cfg.half_duplex_direction, (exp_mode(m) == TPC_FULL_DUPLEX_MODE) ? 1'b0
                : (m[1] ? m[3] : tx_rx_select_pin), "direction");
        end
        spi(0, OFF_DATA_FORMAT_AND_INTERP, 8'h01);
        spi(0, OFF_INTERFACE_MODE_CONFIG, 8'h30);
        chk(cfg.loopback_active, 1'b1, "loop on");
        #1 p = tx_processed;
        clks(1);
        #1 chk(rx_bus_out, p, "loop data");
        clks(20);
        spi(0, OFF_TX_GAIN_UPDATE_CONTROL, 8'h10);
        chk(cfg.gain_quick_settle, 1'b1, "quick settle");
        g = 8'($urandom);
        na = n_apply;
        spi(0, OFF_TX_GAIN_LEVEL, g);
        chk(tx_gain_amp_level, g, "gain level");
        chk(16'(n_apply - na), 16'h0001, "apply now");
        spi(0, OFF_TX_GAIN_UPDATE_CONTROL, 8'h40);
        tx_power_down <= 1'b1;
        na = n_apply;
        spi(0, OFF_TX_GAIN_LEVEL, ~g);
        clks(10);
        chk(16'(n_apply - na), 16'h0000, "apply held");
        tx_power_down <= 1'b0;
        for (int k = 0; k < 10 && n_apply == na; k++) clks(1);
        chk(16'(n_apply - na), 16'h0001, "apply on wake");
        if (n_apply == na) report_and_stop();
        rst_n <= 1'b0;
        clks(3);
        rst_n <= 1'b1;
        clks(1);
        spi(1, OFF_INTERFACE_MODE_CONFIG, 8'h00);
        chk(rd, RST_INTERFACE_MODE_CONFIG, "second reset");
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
